// ==== src/asu_pkg.sv ====
// Purpose: Constants and carriers for the accumulator subtract unit
// Assumes: AXI4-Lite slave, 32-bit data, one word per register
// Notes: Offsets are byte addresses
package asu_pkg;
    // Register byte offsets
    localparam logic [7:0] ASU_ADDR_ACC = 8'h00;
    localparam logic [7:0] ASU_ADDR_FLAGS = 8'h04;
    localparam logic [7:0] ASU_ADDR_CMD = 8'h08;
    localparam logic [7:0] ASU_ADDR_TREG = 8'h0C;
    localparam logic [7:0] ASU_ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ASU_ADDR_IRQ_CLR = 8'h14;
    localparam logic [7:0] ASU_ADDR_IRQ_EN = 8'h18;
    // Flag register bit positions
    localparam int ASU_FLAG_SXM = 0;
    localparam int ASU_FLAG_OVM = 1;
    localparam int ASU_FLAG_CARRY = 2;
    localparam int ASU_FLAG_WRAP = 3;
    // Reset values
    localparam logic ASU_RST_SXM = 1'b1;
    localparam logic ASU_RST_OVM = 1'b0;
    localparam logic ASU_RST_CARRY = 1'b0;
    localparam logic [31:0] ASU_RST_ACC = 32'h0000_0000;
    localparam logic [3:0] ASU_RST_TREG = 4'h0;
    // Operation codes in the command word
    localparam logic [2:0] ASU_OP_TSHIFT = 3'h0;
    localparam logic [2:0] ASU_OP_BORROW = 3'h1;
    localparam logic [2:0] ASU_OP_DIVSTEP = 3'h2;
    localparam logic [2:0] ASU_OP_SHORTIMM = 3'h3;
    localparam logic [2:0] ASU_OP_UNSIGNED = 3'h4;
    // Divide step scaling and saturation limits
    localparam int ASU_DIV_SHIFT = 15;
    localparam logic [31:0] ASU_SAT_POS = 32'h7FFF_FFFF;
    localparam logic [31:0] ASU_SAT_NEG = 32'h8000_0000;
    // Interrupt status bits
    localparam int ASU_IRQ_WRAP = 0;
    localparam int ASU_IRQ_DONE = 1;
    localparam int ASU_IRQ_N = 2;
    // Bus responses
    localparam logic [1:0] ASU_RESP_OKAY = 2'h0;
    localparam logic [1:0] ASU_RESP_SLVERR = 2'h2;
    // Command word written to the command register
    typedef struct packed {
        logic [12:0] spare;
        logic [2:0] op;
        logic [15:0] data;
    } asu_cmd_s;
    // Outcome of one arithmetic step
    typedef struct packed {
        logic [31:0] acc;
        logic carry;
        logic ovf;
    } asu_res_s;
endpackage : asu_pkg

// ==== src/asu_core.sv ====
// Purpose: Accumulator subtract datapath behind an AXI4-Lite slave
// Assumes: Single clock, asynchronous active-low reset
// Notes: A write to the command register runs one step in one cycle
// Contract
// RL1 - Divide step: keep difference or shift accumulator
// RL2 - Sixteen steps leave quotient low, remainder high
// RL3 - Divide divisor extension follows sign mode
// RL4 - Software: sign mode needs divisor MSB clear
// RL5 - Software: dividend stays positive throughout
// RL6 - Software: small dividend may be preshifted
// RL7 - Divide step sets overflow, never saturates
// RL8 - Short immediate: zero-extended byte subtracted
// RL9 - Short immediate updates flags, may saturate
// RL10 - Unsigned: operand zero-extended, accumulator signed
// RL11 - Unsigned equals unshifted subtract, no extension
// RL12 - Borrow subtract takes inverted carry too
// RL13 - Shifted subtract uses T low bits
// RL14 - Carry set when no borrow out
// RL15 - Overflow flag sticky until software clears
`timescale 1ns/1ps
module asu_core (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);
    import asu_pkg::*;

    // Architectural state
    logic [31:0] acc; // Accumulator
    logic sign_extension_mode_bit; // sign_extension_mode_bit
    logic saturate_enable_bit; // saturate_enable_bit
    logic carry; // Carry flag
    logic wrap; // wrap_error_flag
    logic [3:0] treg; // Shift count register
    logic [ASU_IRQ_N-1:0] irq_stat; // Sticky events
    logic [ASU_IRQ_N-1:0] irq_en; // Event enables

    // Write channel helpers
    logic wr_go; // Address and data taken together
    logic [31:0] wr_word; // Byte-merged over zero
    logic go; // Arithmetic step this cycle
    asu_cmd_s cmd; // Decoded command word

    // Datapath helpers
    logic [31:0] opx; // Extended operand
    logic [31:0] sub; // Value subtracted
    logic cin; // Carry into the adder
    logic [32:0] sum; // Adder with carry out
    logic ovf; // Signed overflow of this step
    asu_res_s res; // Step outcome
    logic [ASU_IRQ_N-1:0] irq_ev; // Event pulses
    logic [ASU_IRQ_N-1:0] irq_clr; // Clear pulses

    // Byte lane merge for strobed writes
    function automatic logic [31:0] asu_merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] be
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : asu_merge

    // Both write channels taken in one cycle when no response waits
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign wr_word = asu_merge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
    assign cmd = asu_cmd_s'(wr_word);
    assign go = wr_go && (s_axi_awaddr == ASU_ADDR_CMD);

    // Operand extension by sign mode
    always_comb
    begin
        if (sign_extension_mode_bit)
        begin
            opx = {{16{cmd.data[15]}}, cmd.data}; // [RL3]
        end
        else
        begin
            opx = {16'h0000, cmd.data}; // [RL3]
        end
    end

    // Selects what the adder subtracts
    always_comb
    begin
        cin = 1'b1;
        case (cmd.op)
            ASU_OP_TSHIFT:
            begin
                sub = opx << treg; // [RL13]
            end
            ASU_OP_BORROW:
            begin
                sub = opx;
                cin = carry; // [RL12]
            end
            ASU_OP_DIVSTEP:
            begin
                sub = opx << ASU_DIV_SHIFT; // [RL1]
            end
            ASU_OP_SHORTIMM:
            begin
                sub = {24'h00_0000, cmd.data[7:0]}; // [RL8]
            end
            ASU_OP_UNSIGNED:
            begin
                sub = {16'h0000, cmd.data}; // [RL10] [RL11]
            end
            default:
            begin
                sub = 32'h0000_0000;
            end
        endcase
    end

    // Subtract as add of the complement; carry out means no borrow
    assign sum = {1'b0, acc} + {1'b0, ~sub} + {32'h0000_0000, cin}; // [RL14]
    assign ovf = (acc[31] == ~sub[31]) && (sum[31] != acc[31]);

    // Result shaping: conditional step or saturation
    always_comb
    begin
        res.carry = sum[32]; // [RL14]
        res.ovf = ovf;
        if (cmd.op == ASU_OP_DIVSTEP)
        begin
            // No saturation on this step
            if (!sum[31])
            begin
                res.acc = {sum[30:0], 1'b1}; // [RL1] [RL7]
            end
            else
            begin
                res.acc = {acc[30:0], 1'b0}; // [RL1]
            end
        end
        else if (saturate_enable_bit && ovf)
        begin
            res.acc = acc[31] ? ASU_SAT_NEG : ASU_SAT_POS; // [RL9]
        end
        else
        begin
            res.acc = sum[31:0];
        end
    end

    // Accumulator: step result or direct write
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc <= ASU_RST_ACC;
        end
        else if (go)
        begin
            acc <= res.acc; // [RL2] [RL8]
        end
        else if (wr_go && s_axi_awaddr == ASU_ADDR_ACC)
        begin
            acc <= asu_merge(acc, s_axi_wdata, s_axi_wstrb);
        end
    end

    // Mode bits and carry
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sign_extension_mode_bit <= ASU_RST_SXM;
            saturate_enable_bit <= ASU_RST_OVM;
            carry <= ASU_RST_CARRY;
        end
        else if (go)
        begin
            carry <= res.carry; // [RL9] [RL12] [RL14]
        end
        else if (wr_go && s_axi_awaddr == ASU_ADDR_FLAGS)
        begin
            sign_extension_mode_bit <= s_axi_wstrb[0] ? s_axi_wdata[ASU_FLAG_SXM] : sign_extension_mode_bit;
            saturate_enable_bit <= s_axi_wstrb[0] ? s_axi_wdata[ASU_FLAG_OVM] : saturate_enable_bit;
            carry <= s_axi_wstrb[0] ? s_axi_wdata[ASU_FLAG_CARRY] : carry;
        end
    end

    // Overflow flag: set wins over the write-one clear
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wrap <= 1'b0;
        end
        else if (go && ovf)
        begin
            wrap <= 1'b1; // [RL7] [RL9] [RL15]
        end
        else if (wr_go && s_axi_awaddr == ASU_ADDR_FLAGS && wr_word[ASU_FLAG_WRAP])
        begin
            wrap <= 1'b0; // [RL15]
        end
    end

    // Shift count register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            treg <= ASU_RST_TREG;
        end
        else if (wr_go && s_axi_awaddr == ASU_ADDR_TREG && s_axi_wstrb[0])
        begin
            treg <= s_axi_wdata[3:0];
        end
    end

    // Interrupt events and clears
    assign irq_ev = {go, go && ovf};
    assign irq_clr = (wr_go && s_axi_awaddr == ASU_ADDR_IRQ_CLR) ? wr_word[ASU_IRQ_N-1:0] : '0;

    // Sticky status, enables; set wins over clear
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_stat <= '0;
            irq_en <= '0;
        end
        else
        begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
            if (wr_go && s_axi_awaddr == ASU_ADDR_IRQ_EN)
            begin
                irq_en <= wr_word[ASU_IRQ_N-1:0];
            end
        end
    end

    // Level interrupt
    assign irq = |(irq_stat & irq_en);

    // Write response
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ASU_RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            // Unmapped offsets answer with an error
            s_axi_bresp <= (s_axi_awaddr > ASU_ADDR_IRQ_EN || s_axi_awaddr[1:0] != 2'h0)
                ? ASU_RESP_SLVERR : ASU_RESP_OKAY;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read address taken only when no data waits
    assign s_axi_arready = !s_axi_rvalid;

    // Read data and response
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ASU_RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= ASU_RESP_OKAY;
            case (s_axi_araddr)
                ASU_ADDR_ACC: s_axi_rdata <= acc;
                ASU_ADDR_FLAGS: s_axi_rdata <= {28'h000_0000, wrap, carry, saturate_enable_bit, sign_extension_mode_bit};
                ASU_ADDR_CMD: s_axi_rdata <= 32'h0000_0000; // Write only
                ASU_ADDR_TREG: s_axi_rdata <= {28'h000_0000, treg};
                ASU_ADDR_IRQ_STAT: s_axi_rdata <= {30'h0000_0000, irq_stat};
                ASU_ADDR_IRQ_CLR: s_axi_rdata <= 32'h0000_0000; // Write only
                ASU_ADDR_IRQ_EN: s_axi_rdata <= {30'h0000_0000, irq_en};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= ASU_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checking helpers: divide run tracker
    logic [31:0] chk_div; // Trial difference of a divide step
    logic [4:0] div_n; // Consecutive divide steps
    logic [31:0] div_a; // Dividend at run start
    logic [15:0] div_d; // Divisor of the run
    assign chk_div = acc - 32'(opx << ASU_DIV_SHIFT);

    // Counts a run of divide steps with one divisor
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_n <= 5'h00;
            div_a <= 32'h0000_0000;
            div_d <= 16'h0000;
        end
        else if (go && cmd.op == ASU_OP_DIVSTEP && (div_n == 5'h00 || cmd.data == div_d))
        begin
            if (div_n == 5'h00)
            begin
                div_a <= acc;
                div_d <= cmd.data;
            end
            div_n <= (div_n == 5'h10) ? 5'h10 : div_n + 5'h01;
        end
        else if (go || (wr_go && s_axi_awaddr == ASU_ADDR_ACC))
        begin
            div_n <= 5'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_div_step;
        go && cmd.op == ASU_OP_DIVSTEP |=>
            acc == ($past(chk_div[31]) ? {$past(acc[30:0]), 1'b0} : {$past(chk_div[30:0]), 1'b1});
    endproperty
    a_div_step: assert property (p_div_step) else $error("divide step result wrong"); // [RL1]

    property p_div_run;
        $changed(div_n) && div_n == 5'h10 && div_a[31:15] == 17'h0_0000 && div_d != 16'h0000
            && div_d[15] == 1'b0 |-> acc == {16'(div_a % div_d), 16'(div_a / div_d)};
    endproperty
    a_div_run: assert property (p_div_run) else $error("sixteen steps gave wrong quotient"); // [RL2]

    property p_div_ext;
        go && cmd.op == ASU_OP_DIVSTEP && !sign_extension_mode_bit && cmd.data[15] && acc[31:30] == 2'b00 |=> acc[0] == 1'b0;
    endproperty
    a_div_ext: assert property (p_div_ext) else $error("divisor not zero-extended"); // [RL3]

    property p_div_nosat;
        go && cmd.op == ASU_OP_DIVSTEP && saturate_enable_bit && ovf |=> wrap && acc[0] == !$past(sum[31]);
    endproperty
    a_div_nosat: assert property (p_div_nosat) else $error("divide step saturated"); // [RL7]

    property p_short;
        go && cmd.op == ASU_OP_SHORTIMM && !(saturate_enable_bit && ovf) |=>
            acc == $past(acc) - {24'h00_0000, $past(cmd.data[7:0])};
    endproperty
    a_short: assert property (p_short) else $error("short immediate result wrong"); // [RL8]

    property p_short_sat;
        go && cmd.op == ASU_OP_SHORTIMM && saturate_enable_bit && ovf |=>
            acc == ($past(acc[31]) ? ASU_SAT_NEG : ASU_SAT_POS) && wrap;
    endproperty
    a_short_sat: assert property (p_short_sat) else $error("short immediate not saturated"); // [RL9]

    property p_unsigned;
        go && cmd.op == ASU_OP_UNSIGNED && !(saturate_enable_bit && ovf) |=>
            acc == $past(acc) - {16'h0000, $past(cmd.data)};
    endproperty
    a_unsigned: assert property (p_unsigned) else $error("unsigned result wrong"); // [RL10] [RL11]

    property p_borrow;
        go && cmd.op == ASU_OP_BORROW && !(saturate_enable_bit && ovf) |=>
            acc == $past(acc) - $past(opx) - {31'h0000_0000, !$past(carry)};
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow subtract wrong"); // [RL12]

    property p_tshift;
        go && cmd.op == ASU_OP_TSHIFT && !(saturate_enable_bit && ovf) |=>
            acc == $past(acc) - ($past(opx) << $past(treg));
    endproperty
    a_tshift: assert property (p_tshift) else $error("shifted subtract wrong"); // [RL13]

    property p_carry;
        go && cmd.op != ASU_OP_BORROW |=> carry == ($past(acc) >= $past(sub));
    endproperty
    a_carry: assert property (p_carry) else $error("carry does not match borrow"); // [RL14]

    property p_wrap_hold;
        wrap && !(wr_go && s_axi_awaddr == ASU_ADDR_FLAGS) |=> wrap;
    endproperty
    a_wrap_hold: assert property (p_wrap_hold) else $error("overflow flag dropped"); // [RL15]

    c_div_run: cover property ($changed(div_n) && div_n == 5'h10);
    c_short_sat: cover property (go && cmd.op == ASU_OP_SHORTIMM && saturate_enable_bit && ovf);
    c_borrow: cover property (go && cmd.op == ASU_OP_BORROW && !carry);
    c_irq: cover property ($rose(irq));
endmodule : asu_core

// ==== dv/asu_core_tb.sv ====
// Purpose: Self-checking bench for the accumulator subtract unit
// Assumes: Register map, op codes and flag layout from asu_pkg
// Notes: All traffic goes through the AXI4-Lite port; bready and rready stay high
`timescale 1ns/1ps
module asu_core_tb;
    import asu_pkg::*;
    logic clk = 1'b0; // Core clock
    logic reset_n = 1'b0; // Active-low reset
    logic [7:0] awaddr = 8'h00; // Write address
    logic awvalid = 1'b0; // Write address valid
    logic [31:0] wdata = 32'h0000_0000; // Write data
    logic wvalid = 1'b0; // Write data valid
    logic [7:0] araddr = 8'h00; // Read address
    logic arvalid = 1'b0; // Read address valid
    logic awready, wready, bvalid, arready, rvalid, irq; // Design outputs
    logic [1:0] bresp, rresp; // Response codes
    logic [31:0] rdata; // Read data
    int num_errors = 0; // Mismatch count
    int n_checks = 0; // Comparison count

    // Clock at 40 MHz
    always #12.5 clk = ~clk;

    asu_core dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .irq(irq));

    // Word compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Single bit compare
    task automatic chk_bit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    // One write: address and data together, then wait for the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        @(negedge clk);
        while (!(awready && wready) && n++ < 200) @(negedge clk);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(negedge clk);
        while (!bvalid && n++ < 200) @(negedge clk);
        r = bresp;
        // A wait that ran out counts as a mismatch
        if (n > 200)
        begin
            num_errors++;
        end
        @(posedge clk);
    endtask : wr

    // One read: address, then capture data while it stands
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        @(negedge clk);
        while (!arready && n++ < 200) @(negedge clk);
        @(posedge clk);
        arvalid <= 1'b0;
        @(negedge clk);
        while (!rvalid && n++ < 200) @(negedge clk);
        d = rdata;
        r = rresp;
        // A wait that ran out counts as a mismatch
        if (n > 200)
        begin
            num_errors++;
        end
        @(posedge clk);
    endtask : rd

    // Write, response not judged
    task automatic wok(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
    endtask : wok

    // Read and compare the word
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, exp);
    endtask : rchk

    // Run one step of the datapath
    task automatic cmd(input logic [2:0] op, input logic [15:0] data);
        wok(ASU_ADDR_CMD, {13'h0, op, data});
    endtask : cmd

    // Set mode bits and carry, clearing the sticky wrap flag
    task automatic flags(input logic s, input logic o, input logic c);
        wok(ASU_ADDR_FLAGS, {28'h0, 1'b1, c, o, s});
    endtask : flags

    // Interrupt line level, looked at mid-cycle
    task automatic irq_is(input logic exp);
        @(negedge clk);
        chk_bit(irq, exp);
        @(posedge clk);
    endtask : irq_is

    // Reset values and refused addresses
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        rchk(ASU_ADDR_ACC, ASU_RST_ACC);
        rchk(ASU_ADDR_FLAGS, {28'h0, 1'b0, ASU_RST_CARRY, ASU_RST_OVM, ASU_RST_SXM});
        rchk(ASU_ADDR_TREG, {28'h0, ASU_RST_TREG});
        rchk(ASU_ADDR_IRQ_EN, 32'h0000_0000);
        rchk(ASU_ADDR_CMD, 32'h0000_0000);
        rd(8'h1C, d, r);
        chk(d, 32'h0000_0000);
        chk({30'h0, r}, {30'h0, ASU_RESP_SLVERR});
        wr(8'h01, 32'hFFFF_FFFF, r);
        chk({30'h0, r}, {30'h0, ASU_RESP_SLVERR});
        rchk(ASU_ADDR_ACC, ASU_RST_ACC);
    endtask : t_reset

    // Sixteen divide steps: 100 / 7
    task automatic t_divide;
        flags(1'b0, 1'b0, 1'b0);
        wok(ASU_ADDR_ACC, 32'd100);
        repeat (16) cmd(ASU_OP_DIVSTEP, 16'd7);
        rchk(ASU_ADDR_ACC, 32'h0002_000E);
        // Same dividend preshifted past eight of its idle leading zeros
        wok(ASU_ADDR_ACC, 32'h0000_6400);
        repeat (8) cmd(ASU_OP_DIVSTEP, 16'd7);
        rchk(ASU_ADDR_ACC, 32'h0002_000E);
    endtask : t_divide

    // Divisor extension by mode, and overflow without saturation
    task automatic t_div_mode;
        flags(1'b0, 1'b0, 1'b0);
        wok(ASU_ADDR_ACC, 32'h2000_0000);
        cmd(ASU_OP_DIVSTEP, 16'h8000);
        rchk(ASU_ADDR_ACC, 32'h4000_0000);
        flags(1'b1, 1'b0, 1'b0);
        wok(ASU_ADDR_ACC, 32'h2000_0000);
        cmd(ASU_OP_DIVSTEP, 16'h8000);
        rchk(ASU_ADDR_ACC, 32'hC000_0001);
        flags(1'b1, 1'b1, 1'b0);
        wok(ASU_ADDR_ACC, 32'h7000_0000);
        cmd(ASU_OP_DIVSTEP, 16'h8000);
        rchk(ASU_ADDR_ACC, 32'hE000_0000);
        rchk(ASU_ADDR_FLAGS, 32'h0000_000B);
    endtask : t_div_mode

    // Short immediate: zero-extended byte, borrow, saturation, sticky wrap
    task automatic t_short;
        flags(1'b1, 1'b0, 1'b1);
        wok(ASU_ADDR_ACC, 32'd5);
        cmd(ASU_OP_SHORTIMM, 16'hFFFF);
        rchk(ASU_ADDR_ACC, 32'hFFFF_FF06);
        rchk(ASU_ADDR_FLAGS, 32'h0000_0001);
        flags(1'b1, 1'b1, 1'b0);
        wok(ASU_ADDR_ACC, 32'h8000_0000);
        cmd(ASU_OP_SHORTIMM, 16'h0001);
        rchk(ASU_ADDR_ACC, ASU_SAT_NEG);
        rchk(ASU_ADDR_FLAGS, 32'h0000_000F);
        cmd(ASU_OP_SHORTIMM, 16'h0000);
        rchk(ASU_ADDR_FLAGS, 32'h0000_000F);
        flags(1'b1, 1'b1, 1'b1);
        rchk(ASU_ADDR_FLAGS, 32'h0000_0007);
    endtask : t_short

    // Unsigned subtract against the unshifted subtract with no extension
    task automatic t_unsigned;
        flags(1'b1, 1'b0, 1'b1);
        wok(ASU_ADDR_ACC, 32'h0000_0000);
        cmd(ASU_OP_UNSIGNED, 16'h8000);
        rchk(ASU_ADDR_ACC, 32'hFFFF_8000);
        rchk(ASU_ADDR_FLAGS, 32'h0000_0001);
        flags(1'b0, 1'b0, 1'b1);
        wok(ASU_ADDR_TREG, 32'h0000_0000);
        wok(ASU_ADDR_ACC, 32'h0000_0000);
        cmd(ASU_OP_TSHIFT, 16'h8000);
        rchk(ASU_ADDR_ACC, 32'hFFFF_8000);
    endtask : t_unsigned

    // Shift by the largest count with sign extension
    task automatic t_tshift;
        flags(1'b1, 1'b0, 1'b0);
        wok(ASU_ADDR_TREG, 32'hFFFF_FFFF);
        rchk(ASU_ADDR_TREG, 32'h0000_000F);
        wok(ASU_ADDR_ACC, 32'h0000_0000);
        cmd(ASU_OP_TSHIFT, 16'hFFFF);
        rchk(ASU_ADDR_ACC, 32'h0000_8000);
    endtask : t_tshift

    // Borrow subtract with carry clear and set
    task automatic t_borrow;
        flags(1'b0, 1'b0, 1'b0);
        wok(ASU_ADDR_ACC, 32'd6);
        cmd(ASU_OP_BORROW, 16'd6);
        rchk(ASU_ADDR_ACC, 32'hFFFF_FFFF);
        rchk(ASU_ADDR_FLAGS, 32'h0000_0000);
        flags(1'b0, 1'b0, 1'b1);
        wok(ASU_ADDR_ACC, 32'd6);
        cmd(ASU_OP_BORROW, 16'd6);
        rchk(ASU_ADDR_ACC, 32'h0000_0000);
        rchk(ASU_ADDR_FLAGS, 32'h0000_0004);
    endtask : t_borrow

    // Interrupt raise, clear and mask
    task automatic t_irq;
        wok(ASU_ADDR_IRQ_CLR, 32'h0000_0003);
        wok(ASU_ADDR_IRQ_EN, 32'h0000_0002);
        irq_is(1'b0);
        cmd(ASU_OP_SHORTIMM, 16'h0000);
        irq_is(1'b1);
        rchk(ASU_ADDR_IRQ_STAT, 32'h0000_0002);
        wok(ASU_ADDR_IRQ_CLR, 32'h0000_0002);
        irq_is(1'b0);
        wok(ASU_ADDR_IRQ_EN, 32'h0000_0001);
        cmd(ASU_OP_SHORTIMM, 16'h0000);
        irq_is(1'b0);
        flags(1'b1, 1'b1, 1'b0);
        wok(ASU_ADDR_ACC, 32'h8000_0000);
        cmd(ASU_OP_SHORTIMM, 16'h0001);
        irq_is(1'b1);
        rchk(ASU_ADDR_IRQ_STAT, 32'h0000_0003);
        wok(ASU_ADDR_IRQ_CLR, 32'h0000_0001);
        irq_is(1'b0);
    endtask : t_irq

    // Verdict and end of run
    task automatic results;
        if (num_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // Main sequence after four reset cycles
    initial
    begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_divide();
        t_div_mode();
        t_short();
        t_unsigned();
        t_tshift();
        t_borrow();
        t_irq();
        results();
    end

    // Watchdog, far beyond the expected run
    initial
    begin
        #2000000;
        num_errors++;
        results();
    end
endmodule : asu_core_tb
